// [rtl/usb_host_command_register.v]
// Command register of the enhanced high-speed host controller
// Summary of operation
// - The 32-bit command register sits at offset 20h of the memory window and all bits are read/write.
// - A write makes the controller act on the newly written field values.
// - Bits 23 to 16 hold the interrupt interval field, reset 08h, bounding the interrupt rate.
// - Interval codes 01h, 02h, 04h, 08h, 10h and 20h give that many microframes between interrupts.
// - The low byte holds light reset, doorbell, async enable, periodic enable, two-bit list size, controller reset and run/stop, all reset to zero.
// - Interval code 40h gives sixty-four microframes between interrupts.
// - Writing one to bit 6 rings the doorbell; after eviction the controller clears bit 6 and pulses the advance flag.
// - With async enable clear the async schedule is skipped, otherwise it is fetched from the async list pointer.
// - Bit 7 reads one while a light reset is in progress and zero once complete.
`timescale 1ns/1ps
`include "host_command_defines.vh"

module usb_host_command_register (
	// Clock and reset
	input  wire        clk,
	input  wire        sys_rst,
	// Register access from the memory window
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [11:0] reg_addr,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata,
	// Completion reports from the schedule logic
	input  wire        light_reset_done,
	input  wire        controller_reset_done,
	input  wire        async_cache_evicted,
	// Decoded command outputs
	output reg         run_stop,
	output reg         controller_reset_bit,
	output reg  [1:0]  frame_list_size,
	output reg         periodic_schedule_enable,
	output reg         async_schedule_enable,
	output reg         async_advance_doorbell,
	output reg         light_controller_reset,
	output reg  [7:0]  interrupt_interval_field,
	output reg  [6:0]  interrupt_interval_uframes,
	output reg         async_advance_flag_set,
	output reg         command_written
);

	////////////////////////////////////////////////////////////////////////////
	// Stored fields of the command word
	reg  [7:0]  reserved_high;
	reg  [7:0]  interval_code;
	reg  [7:0]  reserved_low;
	reg         light_busy;
	reg         doorbell_pending;
	reg         async_enable;
	reg         periodic_enable;
	reg  [1:0]  list_size;
	reg         reset_busy;
	reg         run_bit;
	// Next values of the hardware-cleared bits and the advance flag, and the decoded interval count
	reg         next_light_busy;
	reg         next_reset_busy;
	reg         next_doorbell_pending;
	reg         next_flag_set;
	reg  [6:0]  next_uframes;
	// Decoded access
	wire        hit;
	wire        wr_hit;
	wire        rd_hit;
	wire [31:0] host_command_reg;

	////////////////////////////////////////////////////////////////////////////
	// One word lives in the window; writes to every other offset are ignored
	assign hit    = (reg_addr == `CMD_REG_OFFSET);
	assign wr_hit = reg_wr && hit;
	assign rd_hit = reg_rd && hit;

	// Stored word in register bit order
	assign host_command_reg = {reserved_high, interval_code, reserved_low, light_busy,
		doorbell_pending, async_enable, periodic_enable, list_size, reset_busy, run_bit};

	////////////////////////////////////////////////////////////////////////////
	// Undefined codes map to zero so no interval is implied
	always @* begin
		case (reg_wdata[`CMD_ITC_MSB:`CMD_ITC_LSB])
			`ITC_CODE_1:  next_uframes = 7'h01;
			`ITC_CODE_2:  next_uframes = 7'h02;
			`ITC_CODE_4:  next_uframes = 7'h04;
			`ITC_CODE_8:  next_uframes = 7'h08;
			`ITC_CODE_16: next_uframes = 7'h10;
			`ITC_CODE_32: next_uframes = 7'h20;
			`ITC_CODE_64: next_uframes = 7'h40;
			default:      next_uframes = 7'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Hardware completions of the busy bits and the doorbell
	always @* begin
		next_light_busy       = light_busy;
		next_reset_busy       = reset_busy;
		next_doorbell_pending = doorbell_pending;
		next_flag_set         = 1'h0;
		if (light_reset_done) begin
			next_light_busy = 1'h0;
		end
		if (controller_reset_done) begin
			next_reset_busy = 1'h0;
		end
		if (async_cache_evicted && doorbell_pending) begin
			next_doorbell_pending = 1'h0;
			next_flag_set         = 1'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reserved bytes are stored so that their bits read back as written
	always @(posedge clk) begin
		if (sys_rst) begin
			reserved_high <= `CMD_RSVD_RESET;
			reserved_low  <= `CMD_RSVD_RESET;
		end else if (wr_hit) begin
			reserved_high <= reg_wdata[`CMD_RSVD_HI_MSB:`CMD_RSVD_HI_LSB];
			reserved_low  <= reg_wdata[`CMD_RSVD_LO_MSB:`CMD_RSVD_LO_LSB];
		end
	end

	// Invalid codes are stored too; only the decoded count flags them
	always @(posedge clk) begin
		if (sys_rst) begin
			interval_code <= `CMD_ITC_RESET;
		end else if (wr_hit) begin
			interval_code <= reg_wdata[`CMD_ITC_MSB:`CMD_ITC_LSB];
		end
	end

	// Plain control bits: only software changes them
	always @(posedge clk) begin
		if (sys_rst) begin
			run_bit         <= `CMD_BIT_RESET;
			list_size       <= `CMD_FLS_RESET;
			periodic_enable <= `CMD_BIT_RESET;
			async_enable    <= `CMD_BIT_RESET;
		end else if (wr_hit) begin
			run_bit         <= reg_wdata[`CMD_RS_BIT];
			list_size       <= reg_wdata[`CMD_FLS_MSB:`CMD_FLS_LSB];
			periodic_enable <= reg_wdata[`CMD_PSE_BIT];
			async_enable    <= reg_wdata[`CMD_ASE_BIT];
		end
	end

	// A write sets or clears the busy bits itself; otherwise completions clear them
	// Software setting a bit in the same cycle as a completion keeps it set
	always @(posedge clk) begin
		if (sys_rst) begin
			light_busy       <= `CMD_BIT_RESET;
			doorbell_pending <= `CMD_BIT_RESET;
			reset_busy       <= `CMD_BIT_RESET;
		end else if (wr_hit) begin
			light_busy       <= reg_wdata[`CMD_LIGHT_BIT];
			doorbell_pending <= reg_wdata[`CMD_DOORBELL_BIT];
			reset_busy       <= reg_wdata[`CMD_CONTROLLER_RESET_BIT_BIT];
		end else begin
			light_busy       <= next_light_busy;
			doorbell_pending <= next_doorbell_pending;
			reset_busy       <= next_reset_busy;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One-cycle write and flag pulses, plus the decoded interval held until the next write
	always @(posedge clk) begin
		if (sys_rst) begin
			interrupt_interval_uframes <= `CMD_UFRAMES_RESET;
			async_advance_flag_set     <= 1'h0;
			command_written            <= 1'h0;
		end else begin
			command_written        <= wr_hit;
			// Eviction is reported even when software writes in the same cycle
			async_advance_flag_set <= next_flag_set;
			if (wr_hit) begin
				interrupt_interval_uframes <= next_uframes;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Field outputs lag the stored word by one cycle
	// Registered so schedule logic never sees a half-written word
	always @(posedge clk) begin
		if (sys_rst) begin
			run_stop                 <= `CMD_BIT_RESET;
			controller_reset_bit     <= `CMD_BIT_RESET;
			frame_list_size          <= `CMD_FLS_RESET;
			periodic_schedule_enable <= `CMD_BIT_RESET;
			async_schedule_enable    <= `CMD_BIT_RESET;
			async_advance_doorbell   <= `CMD_BIT_RESET;
			light_controller_reset   <= `CMD_BIT_RESET;
			interrupt_interval_field <= `CMD_ITC_RESET;
		end else begin
			run_stop                 <= run_bit;
			controller_reset_bit     <= reset_busy;
			frame_list_size          <= list_size;
			periodic_schedule_enable <= periodic_enable;
			// Schedule logic skips the async list while this is low
			async_schedule_enable    <= async_enable;
			async_advance_doorbell   <= doorbell_pending;
			light_controller_reset   <= light_busy;
			interrupt_interval_field <= interval_code;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data holds until the next read strobe
	// Unmapped reads return zero rather than stale data
	always @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= `CMD_RDATA_RESET;
		end else if (rd_hit) begin
			reg_rdata <= host_command_reg;
		end else if (reg_rd) begin
			reg_rdata <= `CMD_RDATA_RESET;
		end
	end

endmodule // usb_host_command_register

// [rtl/host_command_defines.vh]
// Offsets, field positions, reset values and codes of the host command register
`ifndef HOST_COMMAND_DEFINES_VH
`define HOST_COMMAND_DEFINES_VH

`define CMD_REG_OFFSET     12'h020
`define CMD_RESET_VALUE    32'h0008_0000
`define CMD_RS_BIT         0
`define CMD_CONTROLLER_RESET_BIT_BIT    1
`define CMD_FLS_LSB        2
`define CMD_FLS_MSB        3
`define CMD_PSE_BIT        4
`define CMD_ASE_BIT        5
`define CMD_DOORBELL_BIT   6
`define CMD_LIGHT_BIT      7
`define CMD_ITC_LSB        16
`define CMD_ITC_MSB        23
`define CMD_ITC_RESET      8'h08
`define CMD_RSVD_LO_LSB    8
`define CMD_RSVD_LO_MSB    15
`define CMD_RSVD_HI_LSB    24
`define CMD_RSVD_HI_MSB    31
`define CMD_RSVD_RESET     8'h00
`define CMD_BIT_RESET      1'h0
`define CMD_FLS_RESET      2'h0
`define CMD_UFRAMES_RESET  7'h08
`define CMD_RDATA_RESET    32'h0000_0000
`define ITC_CODE_1         8'h01
`define ITC_CODE_2         8'h02
`define ITC_CODE_4         8'h04
`define ITC_CODE_8         8'h08
`define ITC_CODE_16        8'h10
`define ITC_CODE_32        8'h20
`define ITC_CODE_64        8'h40

`endif

// [test/usb_host_command_chk.sv]
// Checker for the host command register ports
`timescale 1ns/1ps
module usb_host_command_chk (
	input wire        clk, sys_rst, reg_wr, reg_rd, async_cache_evicted, light_reset_done,
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata, reg_rdata,
	input wire        run_stop, async_schedule_enable, async_advance_doorbell,
	input wire        light_controller_reset, async_advance_flag_set, command_written,
	input wire [7:0]  interrupt_interval_field,
	input wire [6:0]  interrupt_interval_uframes
);
	wire w = reg_wr && reg_addr == 12'h020;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_write_pulse: assert property (w |=> command_written) else $error("no write pulse");
	a_stray_pulse: assert property (!w |=> !command_written) else $error("stray pulse");
	a_fields_follow: assert property (w |-> ##2 {run_stop, async_schedule_enable} ==
		{$past(reg_wdata[0], 2), $past(reg_wdata[5], 2)}) else $error("field lag");
	a_interval_follow: assert property (w |-> ##2
		interrupt_interval_field == $past(reg_wdata[23:16], 2)) else $error("interval lag");
	a_code_decode: assert property (w && reg_wdata[23:16] inside {8'h01, 8'h02, 8'h04, 8'h08,
		8'h10, 8'h20, 8'h40} |=> interrupt_interval_uframes == $past(reg_wdata[22:16]))
		else $error("bad decode");
	a_read_unmapped: assert property (
		reg_rd && reg_addr != 12'h020 |=> reg_rdata == 32'h0)
		else $error("unmapped read");
	a_flag_cause: assert property (
		async_advance_flag_set |-> $past(async_cache_evicted))
		else $error("flag uncaused");
	a_door_clear: assert property (
		async_advance_flag_set |=> !async_advance_doorbell)
		else $error("doorbell kept");
	a_light_clear: assert property (
		light_reset_done && !reg_wr |-> ##2 !light_controller_reset)
		else $error("light reset kept");
endmodule // usb_host_command_chk
bind usb_host_command_register usb_host_command_chk chk (
	.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.async_cache_evicted(async_cache_evicted), .light_reset_done(light_reset_done),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.run_stop(run_stop), .async_schedule_enable(async_schedule_enable),
	.async_advance_doorbell(async_advance_doorbell),
	.light_controller_reset(light_controller_reset),
	.async_advance_flag_set(async_advance_flag_set), .command_written(command_written),
	.interrupt_interval_field(interrupt_interval_field),
	.interrupt_interval_uframes(interrupt_interval_uframes)
);

// [test/test_usb_host_command_register.sv]
// Self-checking bench for the host command register
`timescale 1ns/1ps
module test_usb_host_command_register;
	reg        clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	reg        light_reset_done = 1'b0, controller_reset_done = 1'b0, async_cache_evicted = 1'b0;
	reg [11:0] reg_addr = 12'h000;
	reg [31:0] reg_wdata = 32'h0;
	wire [31:0] reg_rdata;
	wire [7:0]  interrupt_interval_field;
	wire [6:0]  interrupt_interval_uframes;
	wire [1:0]  frame_list_size;
	wire run_stop, controller_reset_bit, periodic_schedule_enable, async_schedule_enable;
	wire async_advance_doorbell, light_controller_reset, async_advance_flag_set, command_written;
	integer mismatches = 0, tests_run = 0, i;
	usb_host_command_register DUT (
		.clk(clk),
		.sys_rst(sys_rst),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.light_reset_done(light_reset_done),
		.controller_reset_done(controller_reset_done),
		.async_cache_evicted(async_cache_evicted),
		.run_stop(run_stop),
		.controller_reset_bit(controller_reset_bit),
		.frame_list_size(frame_list_size),
		.periodic_schedule_enable(periodic_schedule_enable),
		.async_schedule_enable(async_schedule_enable),
		.async_advance_doorbell(async_advance_doorbell),
		.light_controller_reset(light_controller_reset),
		.interrupt_interval_field(interrupt_interval_field),
		.interrupt_interval_uframes(interrupt_interval_uframes),
		.async_advance_flag_set(async_advance_flag_set),
		.command_written(command_written)
	);
	initial forever #25 clk = ~clk;
	task chk(input string n, input [31:0] e, input [31:0] g); begin
		tests_run = tests_run + 1;
		if (g !== e) begin
			mismatches = mismatches + 1;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	end endtask
	task acc(input w, input [11:0] a, input [31:0] d); begin
		@(negedge clk);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end endtask
	task rd(input [11:0] a, input [31:0] e); begin
		acc(1'b0, a, 32'h0);
		chk("rdata", e, reg_rdata);
	end endtask
	task pulse(input [2:0] m); begin
		@(negedge clk);
		{light_reset_done, controller_reset_done, async_cache_evicted} = m;
		@(negedge clk);
		{light_reset_done, controller_reset_done, async_cache_evicted} = 3'h0;
		chk("flag", {31'h0, m[0]}, {31'h0, async_advance_flag_set});
	end endtask
	task give_verdict; begin
		$display("Checks %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end endtask
	// Whole run is under 200 cycles
	initial begin
		#20000;
		mismatches = mismatches + 1;
		give_verdict;
	end
	initial begin
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		rd(12'h020, 32'h0008_0000);
		acc(1'b1, 12'h020, 32'h0010_0021);
		@(negedge clk);
		chk("fields", 32'h0010_0021, {8'h0, interrupt_interval_field, 8'h0,
			light_controller_reset, async_advance_doorbell, async_schedule_enable,
			periodic_schedule_enable, frame_list_size, controller_reset_bit, run_stop});
		$display("write test done");
		for (i = 0; i < 7; i = i + 1) begin
			acc(1'b1, 12'h020, 32'h0001_0000 << i);
			chk("uframes", 32'h1 << i, {25'h0, interrupt_interval_uframes});
		end
		rd(12'h020, 32'h0040_0000);
		$display("interval test done");
		acc(1'b1, 12'h020, 32'h0008_00C2);
		rd(12'h020, 32'h0008_00C2);
		pulse(3'h7);
		rd(12'h020, 32'h0008_0000);
		$display("busy bit test done");
		acc(1'b1, 12'h024, 32'hFFFF_FFFF);
		rd(12'h020, 32'h0008_0000);
		rd(12'h024, 32'h0);
		$display("unmapped test done");
		give_verdict;
	end
endmodule // test_usb_host_command_register
